// [hw/hpst_fifo.sv]
`default_nettype none
module hpst_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             rst_in,
   // Fill side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out,
   // Flush on reload
   input  wire logic             flush_in
);
   localparam int AW = $clog2(DEPTH);
   initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
   logic [AW:0]      wp_q;           // Write pointer, extra wrap bit
   logic [AW:0]      rp_q;           // Read pointer
   logic             push;
   logic             pop;
   assign in_ready_out  = (wp_q - rp_q) != (AW+1)'(DEPTH);
   assign out_valid_out = wp_q != rp_q;
   assign out_data_out  = mem_q[rp_q[AW-1:0]];
   assign push = in_valid_in && in_ready_out;
   assign pop  = out_valid_out && out_ready_in;
   // Pointers
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || flush_in) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
      end
   end
   // Storage write
   always_ff @(posedge clk_sys_in) begin
      if (push) mem_q[wp_q[AW-1:0]] <= in_data_in;
   end
endmodule
`default_nettype wire

// [hw/hpst_host_port.sv]
`default_nettype none
module hpst_host_port #(
   parameter int FIFO_DEPTH = 32,
   parameter int BUILT_IN_SELF_CHECK_CLKS  = hpst_pkg::BUILT_IN_SELF_CHECK_PHASE_CLKS,
   parameter logic [3:0] MASK_REV = 4'h3  // Arbitrary revision code
) (
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   // Host parallel bus (pins)
   input  wire logic        host_wr_in,
   input  wire logic        host_rd_in,
   input  wire logic [1:0]  host_addr_in,
   input  wire logic [15:0] host_data_in,
   output logic [15:0]      host_data_out,
   output logic             host_data_oe_out,
   // Output sample stream from channels
   input  wire logic        sample_valid_in,
   output logic             sample_ready_out,
   input  wire logic [15:0] sample_data_in,
   input  wire logic        fifo_reload_in,
   // Sync pins
   input  wire logic        sync_input_in,
   output logic             sync_output_out,
   output logic             sync_internal_out,
   // Channel controls
   output logic [3:0]       filter_engine_hold_out,
   output logic [3:0]       chan_soft_reset_out,
   output logic [3:0]       engine_ready_out,
   output logic             built_in_self_check_active_out,
   output logic [22:0]      built_in_self_check_pn_out,
   output logic             ram_test_out,
   // Internal write and read strobes toward channel registers
   output logic             iwr_stb_out,
   output logic [15:0]      iwr_addr_out,
   output logic [31:0]      iwr_data_out,
   output logic             ird_stb_out,
   output logic [15:0]      ird_addr_out,
   input  wire logic [31:0] ird_data_in
);
   initial if (BUILT_IN_SELF_CHECK_CLKS < 2) $error("BUILT_IN_SELF_CHECK_CLKS too small");

   // Pin synchronisers
   logic [1:0] wr_s_q, rd_s_q, sy_s_q;
   logic [1:0] a0_q, a1_q;
   logic [15:0] d0_q, d1_q;
   always_ff @(posedge clk_sys_in) begin
      wr_s_q <= {wr_s_q[0], host_wr_in};
      rd_s_q <= {rd_s_q[0], host_rd_in};
      sy_s_q <= {sy_s_q[0], sync_input_in};
      a0_q   <= host_addr_in;
      a1_q   <= a0_q;
      d0_q   <= host_data_in;
      d1_q   <= d0_q;
   end
   // Edge detection on the settled strobes
   logic wr_d_q, rd_d_q;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         wr_d_q <= 1'b0;
         rd_d_q <= 1'b0;
      end else begin
         wr_d_q <= wr_s_q[1];
         rd_d_q <= rd_s_q[1];
      end
   end
   hpst_pkg::hpst_bus_type bus;
   assign bus.wr   = wr_s_q[1] && !wr_d_q;
   assign bus.rd   = !rd_s_q[1] && rd_d_q;  // End of read
   assign bus.addr = a1_q;
   assign bus.data = d1_q;
   logic rd_active;
   assign rd_active = rd_s_q[1];

   // Holding registers and internal addresses
   logic [31:0] hold_q;      // Write holding
   logic [15:0] radr_q;      // Read source
   logic [2:0]  xfer_q;      // Transfer pipe, four clocks end to end
   logic [15:0] wadr_q;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         hold_q <= '0;
         wadr_q <= '0;
         radr_q <= '0;
         xfer_q <= '0;
      end else begin
         if (bus.wr && bus.addr == hpst_pkg::DA_LOW) hold_q[15:0] <= bus.data;
         if (bus.wr && bus.addr == hpst_pkg::DA_HIGH) hold_q[31:16] <= bus.data;
         if (bus.wr && bus.addr == hpst_pkg::DA_WADR) wadr_q <= bus.data;
         if (bus.wr && bus.addr == hpst_pkg::DA_RADR) radr_q <= bus.data;
         // Synchronise then strobe on the fourth clock
         xfer_q <= {xfer_q[1:0], bus.wr && bus.addr == hpst_pkg::DA_WADR};
      end
   end
   hpst_pkg::hpst_iwr_type iwr;
   assign iwr.stb  = xfer_q[2];
   assign iwr.addr = wadr_q;
   assign iwr.data = hold_q;
   logic [3:0] csel;     // Channel select, nibble F hits all
   logic       chan_hit;
   assign chan_hit = iwr.addr[15:12] < 4'h4 || iwr.addr[15:12] == hpst_pkg::CH_ALL;
   generate
      for (genvar c = 0; c < 4; c++) begin : g_sel
         assign csel[c] = chan_hit &&
            (iwr.addr[15:12] == 4'(c) || iwr.addr[15:12] == hpst_pkg::CH_ALL);
      end
   endgenerate

   // Global control, signature and sync
   logic [31:0] ctrl_q;
   logic [15:0] sig_exp_q;
   logic [15:0] sig_q;
   logic        match_q;
   logic        sync_o_q, sync_i_q;
   logic [1:0]  phase_q;     // Phases done since reset, cleared by the start that follows the second phase
   logic [$clog2(BUILT_IN_SELF_CHECK_CLKS+1)-1:0] bcnt_q;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ctrl_q   <= hpst_pkg::TEST_CTRL_RST;
         sig_exp_q <= '0;
         sync_o_q <= 1'b0;
         sync_i_q <= 1'b0;
      end else begin
         sync_o_q <= iwr.stb && (iwr.addr == hpst_pkg::GA_SYNC_BOTH ||
                                 iwr.addr == hpst_pkg::GA_SYNC_OUT);
         sync_i_q <= (iwr.stb && iwr.addr == hpst_pkg::GA_SYNC_BOTH) || sy_s_q[1];
         if (iwr.stb && iwr.addr == hpst_pkg::GA_SIGNATURE) sig_exp_q <= iwr.data[15:0];
         // Start write sets busy next clock; busy ends with the final count
         if (iwr.stb && iwr.addr == hpst_pkg::GA_TEST_CTRL)
            ctrl_q <= iwr.data;
         else if (ctrl_q[hpst_pkg::BIT_BUILT_IN_SELF_CHECK_RUN] && bcnt_q == 1)
            ctrl_q[hpst_pkg::BIT_BUILT_IN_SELF_CHECK_RUN] <= 1'b0;
      end
   end
   // Self test: PN source and signature register
   logic [22:0] pn_q;
   logic [15:0] sig_nxt;  // Signature after folding in the current sample
   // Shared by the update and the final compare, so the last sample counts too
   assign sig_nxt = {sig_q[14:0], sig_q[15] ^ sig_q[4] ^ sig_q[3]} ^ sample_data_in ^
                    {sig_q[15] ? 16'h1021 : 16'h0000};
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         pn_q    <= hpst_pkg::PN_SEED;
         sig_q   <= hpst_pkg::SIG_SEED;
         bcnt_q  <= '0;
         phase_q <= '0;
         match_q <= 1'b0;
      end else if (iwr.stb && iwr.addr == hpst_pkg::GA_TEST_CTRL && iwr.data[0]) begin
         bcnt_q <= ($bits(bcnt_q))'(BUILT_IN_SELF_CHECK_CLKS);
         pn_q   <= hpst_pkg::PN_SEED;
         if (phase_q == 2'h2) begin
            phase_q <= '0;
            sig_q   <= hpst_pkg::SIG_SEED;
            match_q <= 1'b0;
         end
      end else if (bcnt_q != 0) begin
         // PN replaces channel input while counting
         pn_q   <= {pn_q[21:0], pn_q[22] ^ pn_q[17]};
         bcnt_q <= bcnt_q - 1'b1;
         if (sample_valid_in)  // Signature from output data
            sig_q <= sig_nxt;
         if (bcnt_q == 1) begin
            phase_q <= phase_q + 2'h1;
            // Compare the final value, including a sample arriving on the last count
            if (phase_q == 2'h1)
               match_q <= (sample_valid_in ? sig_nxt : sig_q) == sig_exp_q;
         end
      end
   end

   // Channel hold, software reset, engine release timers
   logic [3:0] hold_q4, srst_q;
   logic [5:0] rel_q [4];
   logic [3:0] erdy_q;
   generate
      for (genvar c = 0; c < 4; c++) begin : g_ch
         always_ff @(posedge clk_sys_in) begin
            if (rst_in) begin
               hold_q4[c] <= 1'b0;
               srst_q[c]  <= 1'b0;
               rel_q[c]   <= '0;
               erdy_q[c]  <= 1'b0;
            end else begin
               // Any write to the reset offset resets the channel
               srst_q[c] <= iwr.stb && csel[c] && iwr.addr[11:0] == hpst_pkg::CA_CHAN_RESET;
               if (iwr.stb && csel[c] && iwr.addr[11:0] == hpst_pkg::CA_ENGINE_CTRL) begin
                  hold_q4[c] <= iwr.data[hpst_pkg::BIT_HOLD];
                  if (!iwr.data[hpst_pkg::BIT_HOLD] && hold_q4[c]) begin
                     rel_q[c]  <= 6'(hpst_pkg::HOLD_RELEASE_CLKS);
                     erdy_q[c] <= 1'b0;
                  end else if (iwr.data[hpst_pkg::BIT_HOLD]) erdy_q[c] <= 1'b0;
               end else if (rel_q[c] != 0) begin
                  rel_q[c] <= rel_q[c] - 6'h1;
                  if (rel_q[c] == 6'h1) erdy_q[c] <= 1'b1;
               end else if (!hold_q4[c]) erdy_q[c] <= 1'b1;
            end
         end
      end
   endgenerate

   // Filter engine data RAM test access
   // Four channels of 1536 words each; gaps in the map are never stored
   logic [23:0] dram_q [hpst_pkg::RAM_WORDS];
   logic [23:0] dram_rd_q;  // Registered so the index logic stays off the read path
   logic        dram_ok;    // Read source lies inside a valid window
   // Valid test addresses: lower bank, then upper bank, gaps refused
   function automatic logic map_ok(input logic [11:0] a);
      map_ok = a <= hpst_pkg::RAM_TOP &&
               !(a >= hpst_pkg::RAM_UNUSED_LO && a <= hpst_pkg::RAM_UNUSED_HI);
   endfunction
   // Even Q, odd I; upper bank packed right after the lower one
   function automatic logic [12:0] map_idx(input logic [1:0] ch, input logic [11:0] a);
      map_idx = 13'(ch) * 13'd1536 + (a[10] ? 13'(a[9:0]) + 13'h300 : 13'(a[9:0]));
   endfunction
   assign dram_ok = map_ok(radr_q[11:0]) && radr_q[15:12] < 4'h4;
   always_ff @(posedge clk_sys_in) begin
      for (int c = 0; c < 4; c++) begin
         if (ctrl_q[hpst_pkg::BIT_RAM_TEST] && iwr.stb && csel[c] && map_ok(iwr.addr[11:0]))
            dram_q[map_idx(2'(c), iwr.addr[11:0])] <= iwr.data[23:0];
      end
      // Any address, any order
      dram_rd_q <= dram_q[map_idx(radr_q[13:12], radr_q[11:0])];
   end

   // Indirect read capture, after read select settles
   logic [31:0] rhold_q;
   logic [2:0]  rsel_q;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         rsel_q  <= '0;
         rhold_q <= '0;
      end else begin
         rsel_q <= {rsel_q[1:0], bus.wr && bus.addr == hpst_pkg::DA_RADR};
         if (rsel_q[2]) begin
            if (radr_q == hpst_pkg::GA_SIGNATURE) rhold_q <= {sig_q, sig_exp_q};
            else if (radr_q == hpst_pkg::GA_TEST_CTRL) rhold_q <= ctrl_q;
            else if (ctrl_q[hpst_pkg::BIT_RAM_TEST] && dram_ok) rhold_q <= {8'h00, dram_rd_q};
            else rhold_q <= ird_data_in;
         end
      end
   end

   // Output FIFO in the data path
   logic [15:0] fifo_data;
   logic        fifo_valid;
   logic        fifo_pop;
   assign fifo_pop = bus.rd && bus.addr == hpst_pkg::DA_WADR;  // Advance at read end
   hpst_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys_in    (clk_sys_in),
      .rst_in        (rst_in),
      .in_valid_in   (sample_valid_in),
      .in_ready_out  (sample_ready_out),
      .in_data_in    (sample_data_in),
      .out_valid_out (fifo_valid),
      .out_ready_in  (fifo_pop),
      .out_data_out  (fifo_data),
      .flush_in      (fifo_reload_in)
   );

   // Status word, read without side effects
   logic [15:0] status;
   assign status = {3'b000, match_q, !rst_in, 4'h0, sy_s_q[1], MASK_REV, 1'b0,
                    !fifo_valid};

   // Host read data, registered
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         host_data_out    <= '0;
         host_data_oe_out <= 1'b0;
      end else begin
         host_data_oe_out <= rd_active;
         case (bus.addr)
            hpst_pkg::DA_LOW:  host_data_out <= rhold_q[15:0];
            hpst_pkg::DA_HIGH: host_data_out <= rhold_q[31:16];
            hpst_pkg::DA_WADR: host_data_out <= fifo_valid ? fifo_data : 16'h0000;
            default:           host_data_out <= status;
         endcase
      end
   end

   // Registered outputs toward the channels
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         iwr_stb_out  <= 1'b0;
         iwr_addr_out <= '0;
         iwr_data_out <= '0;
         ird_stb_out  <= 1'b0;
         ird_addr_out <= '0;
         built_in_self_check_pn_out  <= '0;
      end else begin
         iwr_stb_out  <= iwr.stb;
         iwr_addr_out <= iwr.addr;
         iwr_data_out <= iwr.data;
         ird_stb_out  <= rsel_q[0];
         ird_addr_out <= radr_q;
         built_in_self_check_pn_out  <= pn_q;
      end
   end
   assign sync_output_out        = sync_o_q;
   assign sync_internal_out      = sync_i_q;
   assign filter_engine_hold_out = hold_q4;
   assign chan_soft_reset_out    = srst_q;
   assign engine_ready_out       = erdy_q;
   assign built_in_self_check_active_out        = ctrl_q[hpst_pkg::BIT_BUILT_IN_SELF_CHECK_RUN];
   assign ram_test_out           = ctrl_q[hpst_pkg::BIT_RAM_TEST];
endmodule
`default_nettype wire

// [include/hpst_pkg.sv]
`default_nettype none
package hpst_pkg;
   // Direct addresses on the host port
   localparam logic [1:0] DA_LOW  = 2'h0;
   localparam logic [1:0] DA_HIGH = 2'h1;
   localparam logic [1:0] DA_WADR = 2'h2;
   localparam logic [1:0] DA_RADR = 2'h3;
   // Global register addresses
   localparam logic [15:0] GA_TEST_CTRL = 16'hf800;
   localparam logic [15:0] GA_SYNC_OUT  = 16'hf809;
   localparam logic [15:0] GA_SYNC_BOTH = 16'hf80a;
   localparam logic [15:0] GA_SIGNATURE = 16'hf80b;
   // Channel register offsets (low 12 bits)
   localparam logic [11:0] CA_ENGINE_CTRL = 12'h00a;
   localparam logic [11:0] CA_CHAN_RESET  = 12'h019;
   localparam logic [3:0]  CH_ALL         = 4'hf;
   // Field positions
   localparam int BIT_BUILT_IN_SELF_CHECK_RUN   = 0;
   localparam int BIT_RAM_TEST   = 15;
   localparam int BIT_HOLD       = 31;
   localparam int ST_FIFO_EMPTYN = 0;
   localparam int ST_SIG_MATCH   = 12;
   // Data RAM test map
   localparam logic [11:0] RAM_UNUSED_LO = 12'h300;
   localparam logic [11:0] RAM_UNUSED_HI = 12'h3ff;
   localparam logic [11:0] RAM_TOP       = 12'h6ff;
   localparam int          RAM_WORDS     = 6144;
   // Reset values
   localparam logic [31:0] TEST_CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] SIG_SEED      = 16'hffff;
   localparam logic [22:0] PN_SEED       = 23'h7f_ffff;
   // Timing counts
   localparam int CLK_NS            = 20;
   localparam int XFER_CLOCKS       = 4;
   localparam int HOLD_RELEASE_CLKS = 32;
   localparam int BUILT_IN_SELF_CHECK_PHASE_CLKS   = 1024;
   // Host bus strobe group
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [1:0]  addr;
      logic [15:0] data;
   } hpst_bus_type;
   // Internal write strobe group
   typedef struct packed {
      logic        stb;
      logic [15:0] addr;
      logic [31:0] data;
   } hpst_iwr_type;
endpackage
`default_nettype wire

// [verif/hpst_checker.sv]
`default_nettype none
module hpst_checker #(
   parameter int BUILT_IN_SELF_CHECK_CLKS = 1024
) (
   // Clock and reset
   input wire logic        clk_sys_in,
   input wire logic        rst_in,
   // Watched pins
   input wire logic        host_rd_in,
   input wire logic        host_data_oe_out,
   input wire logic        sync_output_out,
   input wire logic        sync_internal_out,
   input wire logic [3:0]  filter_engine_hold_out,
   input wire logic [3:0]  chan_soft_reset_out,
   input wire logic [3:0]  engine_ready_out,
   input wire logic        built_in_self_check_active_out,
   input wire logic [22:0] built_in_self_check_pn_out,
   input wire logic        iwr_stb_out,
   input wire logic        ird_stb_out
);
   default clocking @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);
   // Cycles spent busy in the running phase
   int act_q;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || !built_in_self_check_active_out) begin
         act_q <= 0;
      end else begin
         act_q <= act_q + 1;
      end
   end
   // Hold release, then a quiet wait before the engine is usable
   sequence hold_drop;
      $fell(filter_engine_hold_out[0]);
   endsequence
   sequence ready_late;
      (!engine_ready_out[0])[*8] ##[22:26] engine_ready_out[0];
   endsequence
   // Read strobe absent long enough to flush the synchroniser
   sequence rd_idle;
      (!host_rd_in)[*6];
   endsequence
   chk_engine_wait: assert property (hold_drop |-> ready_late)
      else $error("engine ready not 32 clocks after hold release");
   chk_busy_min: assert property ($fell(built_in_self_check_active_out) |-> act_q >= BUILT_IN_SELF_CHECK_CLKS - 2)
      else $error("self test busy cleared early");
   chk_busy_end: assert property ($rose(built_in_self_check_active_out) |-> ##[1:1000] !built_in_self_check_active_out)
      else $error("self test busy never cleared");
   chk_pn_running: assert property (built_in_self_check_active_out && $past(built_in_self_check_active_out, 2) |-> built_in_self_check_pn_out != 23'h0)
      else $error("noise source stuck at zero");
   chk_sync_pair: assert property (sync_internal_out |-> sync_output_out)
      else $error("internal sync without sync out");
   chk_sync_pulse: assert property (sync_output_out |=> !sync_output_out)
      else $error("sync out longer than one clock");
   chk_iwr_pulse: assert property (iwr_stb_out |=> !iwr_stb_out)
      else $error("write strobe longer than one clock");
   chk_ird_pulse: assert property (ird_stb_out |=> !ird_stb_out)
      else $error("read strobe longer than one clock");
   chk_rst_pulse: assert property (|chan_soft_reset_out |=> chan_soft_reset_out == 4'h0)
      else $error("channel reset longer than one clock");
   chk_read_oe: assert property (rd_idle |-> !host_data_oe_out)
      else $error("bus driven without a read");
endmodule
`default_nettype wire

// [verif/hpst_host_model.sv]
`default_nettype none
module hpst_host_model (
   // Clock
   input  wire logic        clk_sys_in,
   // Host bus toward the port
   output var logic         wr_out,
   output var logic         rd_out,
   output var logic [1:0]   addr_out,
   output var logic [15:0]  data_out,
   input  wire logic [15:0] rdata_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 2'h0;
      data_out = 16'h0;
   end
   // Direct write, strobe long enough for the pin synchroniser
   task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      #1;
      addr_out = a;
      data_out = d;
      wr_out = 1'b1;
      repeat (4) @(posedge clk_sys_in);
      #1;
      wr_out = 1'b0;
      data_out = ~d;  // Released bus never keeps its last value
      repeat (4) @(posedge clk_sys_in);  // Spacing and transfer wait
   endtask
   // Direct read; data stands until the address moves, or for the FIFO address until read end
   task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk_sys_in);
      #1;
      addr_out = a;
      rd_out = 1'b1;
      repeat (5) @(posedge clk_sys_in);
      d = rdata_in;
      #1;
      rd_out = 1'b0;
      repeat (4) @(posedge clk_sys_in);
   endtask
   // Indirect write: low half, high half, then target address
   task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
      bus_wr(2'h0, d[15:0]);
      bus_wr(2'h1, d[31:16]);
      bus_wr(2'h2, a);
   endtask
   // Indirect read: select source, then both halves
   task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
      bus_wr(2'h3, a);
      bus_rd(2'h0, d[15:0]);
      bus_rd(2'h1, d[31:16]);
   endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BUILT_IN_SELF_CHECK_CLKS = 16;  // Short phase for simulation
   logic        clk_sys_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        hwr, hrd, hoe, sync_o, sync_i, built_in_self_check_act, ram_test, iwr_stb, ird_stb;
   logic [1:0]  haddr;
   logic [15:0] hwd, hrdata, iwr_addr, ird_addr, w_addr;
   logic        sv = 1'b0;  // Sample source valid
   logic        s_ready;
   logic        reload = 1'b0;
   logic [15:0] sd = 16'h0;
   logic [3:0]  hold, srst, eready, rst_last;
   logic [31:0] iwr_data, w_data;
   logic [22:0] pn;
   int          so_cnt = 0, si_cnt = 0, n_fail = 0, num_checks = 0;
   // Channel read data stand-in, derived from the selected source
   function automatic logic [31:0] chan_word(input logic [15:0] a);
      return {a ^ 16'h5a5a, a};
   endfunction
   always #10 clk_sys_in = ~clk_sys_in;
   hpst_host_port #(.BUILT_IN_SELF_CHECK_CLKS(BUILT_IN_SELF_CHECK_CLKS)) uut (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .host_wr_in(hwr), .host_rd_in(hrd),
      .host_addr_in(haddr), .host_data_in(hwd), .host_data_out(hrdata),
      .host_data_oe_out(hoe), .sample_valid_in(sv), .sample_ready_out(s_ready),
      .sample_data_in(sd), .fifo_reload_in(reload), .sync_input_in(1'b0),
      .sync_output_out(sync_o), .sync_internal_out(sync_i),
      .filter_engine_hold_out(hold), .chan_soft_reset_out(srst),
      .engine_ready_out(eready), .built_in_self_check_active_out(built_in_self_check_act), .built_in_self_check_pn_out(pn),
      .ram_test_out(ram_test), .iwr_stb_out(iwr_stb), .iwr_addr_out(iwr_addr),
      .iwr_data_out(iwr_data), .ird_stb_out(ird_stb), .ird_addr_out(ird_addr),
      .ird_data_in(chan_word(ird_addr)));
   hpst_host_model host (
      .clk_sys_in(clk_sys_in), .wr_out(hwr), .rd_out(hrd), .addr_out(haddr),
      .data_out(hwd), .rdata_in(hrdata));
   // Record what the internal strobes carried
   always @(posedge clk_sys_in) begin
      if (iwr_stb) begin
         w_addr <= iwr_addr;
         w_data <= iwr_data;
      end
      if (|srst) rst_last <= srst;
      so_cnt <= so_cnt + int'(sync_o);
      si_cnt <= si_cnt + int'(sync_i);
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      if (n_fail == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic do_reset();
      @(posedge clk_sys_in);
      #1;
      rst_in = 1'b1;
      repeat (16) @(posedge clk_sys_in);
      #1;
      rst_in = 1'b0;
   endtask
   // Bounded wait on the busy level; a stuck flag shows as a mismatch
   task automatic wait_busy(input logic lvl);
      int i;
      i = 0;
      #1;
      while (built_in_self_check_act !== lvl && i < 200) begin
         @(posedge clk_sys_in);
         i++;
      end
      check(32'(built_in_self_check_act), 32'(lvl));
   endtask
   task automatic built_in_self_check_run();
      repeat (2) begin
         host.reg_wr(16'hf019, 32'h0);
         host.reg_wr(16'hf800, 32'h1);
         wait_busy(1'b1);
         wait_busy(1'b0);
      end
   endtask
   // Hang guard, well above the expected run length
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      n_fail++;
      results();
   end
   initial begin
      logic [31:0] v;
      logic [15:0] s, sig;
      do_reset();
      host.bus_rd(2'h3, s);
      check(32'(s), 32'h080d);
      host.reg_wr(16'hf808, 32'h0);
      host.reg_wr(16'hf801, 32'h0);
      host.reg_wr(16'hf802, 32'h0);
      host.reg_wr(16'h100a, 32'h8000_0000);
      check(32'(hold), 32'h2);
      check(w_data, 32'h8000_0000);
      // Data RAM window: Q then I, read back out of order
      host.reg_wr(16'hf800, 32'h8000);
      check(32'(ram_test), 32'h1);
      host.reg_wr(16'h1400, 32'h00ab_cdef);
      host.reg_wr(16'h1401, 32'h0012_3456);
      check({w_addr, w_data[15:0]}, 32'h1401_3456);
      for (int k = 1; k >= 0; k--) begin
         host.reg_rd(16'h1400 + 16'(k), v);
         check(v, (k == 1) ? 32'h0012_3456 : 32'h00ab_cdef);
      end
      check(32'(ird_addr), 32'h1400);
      host.reg_wr(16'hf800, 32'h0);
      check(32'(ram_test), 32'h0);
      host.reg_wr(16'h100a, 32'h0);
      check(32'(eready[1]), 32'h0);
      repeat (40) @(posedge clk_sys_in);
      check(32'(eready[1]), 32'h1);
      host.reg_wr(16'h1019, 32'h0);
      check(32'(rst_last), 32'h2);
      host.reg_wr(16'hf80a, 32'h0);
      check({16'(so_cnt), 16'(si_cnt)}, 32'h0001_0001);
      host.reg_wr(16'hf809, 32'h0);
      check({16'(so_cnt), 16'(si_cnt)}, 32'h0002_0001);
      host.reg_wr(16'hf00a, 32'h8000_0000);
      check(32'(hold), 32'hf);
      host.reg_wr(16'hf00a, 32'h0);
      host.reg_wr(16'hf019, 32'h0);
      check(32'(rst_last), 32'hf);
      // Fill the buffer until it refuses, then drain it empty
      @(posedge clk_sys_in);
      #1;
      reload = 1'b1;
      @(posedge clk_sys_in);
      #1;
      reload = 1'b0;
      sv = 1'b1;
      for (int i = 0; i < 34; i++) begin
         sd = (i < 32) ? 16'ha000 + 16'(i) : 16'hdead;
         @(posedge clk_sys_in);
         #1;
      end
      check(32'(s_ready), 32'h0);
      sv = 1'b0;
      host.bus_rd(2'h3, s);
      check(32'(s[0]), 32'h0);
      for (int i = 0; i < 32; i++) begin
         host.bus_rd(2'h2, s);
         check(32'(s), 32'ha000 + i);
         if (i == 5) host.bus_rd(2'h3, s);
      end
      host.bus_rd(2'h2, s);
      check(32'(s), 32'h0);
      host.bus_rd(2'h3, s);
      check(32'(s), 32'h080d);
      // Two-phase self test, then a rerun against the learned signature
      host.reg_wr(16'hf80b, 32'h1234);
      built_in_self_check_run();
      host.reg_rd(16'hf80b, v);
      check(32'(v[15:0]), 32'h1234);
      sig = v[31:16];
      do_reset();
      host.reg_wr(16'hf80b, 32'(sig));
      built_in_self_check_run();
      host.reg_rd(16'hf80b, v);
      check(v, {sig, sig});
      host.bus_rd(2'h3, s);
      check(32'(s), 32'h180d);
      results();
   end
endmodule
bind hpst_host_port hpst_checker #(.BUILT_IN_SELF_CHECK_CLKS(BUILT_IN_SELF_CHECK_CLKS)) u_chk (
   .clk_sys_in(clk_sys_in), .rst_in(rst_in), .host_rd_in(host_rd_in),
   .host_data_oe_out(host_data_oe_out), .sync_output_out(sync_output_out),
   .sync_internal_out(sync_internal_out), .filter_engine_hold_out(filter_engine_hold_out),
   .chan_soft_reset_out(chan_soft_reset_out), .engine_ready_out(engine_ready_out),
   .built_in_self_check_active_out(built_in_self_check_active_out), .built_in_self_check_pn_out(built_in_self_check_pn_out),
   .iwr_stb_out(iwr_stb_out), .ird_stb_out(ird_stb_out));
`default_nettype wire
